// ===== inc/cdcr_pkg.sv
// Package for the cable diagnostic calibration register bank: map, fields, reset values, types
package cdcr_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [11:0] IDX_REF_0M = 12'h898;
   localparam logic [11:0] IDX_REF_200M = 12'h899;
   localparam logic [11:0] IDX_REF_400M = 12'h89a;
   localparam logic [11:0] IDX_REF_600M = 12'h89b;
   localparam logic [11:0] IDX_REF_800M = 12'h89c;
   localparam logic [11:0] IDX_REF_1000M = 12'h89d;
   localparam logic [11:0] IDX_CAL_0 = 12'h8e9;
   localparam logic [11:0] IDX_CAL_1 = 12'h8ea;
   localparam logic [11:0] IDX_CAL_2 = 12'h8eb;
   localparam logic [11:0] IDX_CAL_3 = 12'h8ec;
   localparam logic [11:0] IDX_CAL_4 = 12'h8ed;
   localparam logic [11:0] IDX_CAL_5 = 12'h8ee;
   localparam logic [11:0] IDX_METRIC = 12'ha9d;
   localparam logic [11:0] IDX_STATUS = 12'ha9f;
   localparam logic [11:0] IDX_CTRL = 12'ha00;
   localparam logic [11:0] IDX_IRQ_STAT = 12'ha01;
   localparam logic [11:0] IDX_IRQ_MASK = 12'ha02;

   // Tables of indices, entry 0 first
   localparam logic [5:0][11:0] REF_IDX = {IDX_REF_1000M, IDX_REF_800M, IDX_REF_600M,
                                           IDX_REF_400M, IDX_REF_200M, IDX_REF_0M};
   localparam logic [5:0][11:0] CAL_IDX = {IDX_CAL_5, IDX_CAL_4, IDX_CAL_3,
                                           IDX_CAL_2, IDX_CAL_1, IDX_CAL_0};

   // Reset values, entry 0 first
   localparam logic [5:0][11:0] REF_RST = {12'h107, 12'h0b2, 12'h089, 12'h058, 12'h041, 12'h02e};
   localparam logic [5:0][7:0] CAL_RST = {8'h7a, 8'h64, 8'h51, 8'h2f, 8'h19, 8'h00};

   // Field positions
   localparam int METRIC_LSB = 4;
   localparam int STAT_DONE_BIT = 15;
   localparam int CTRL_START_BIT = 0;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_RANGE_BIT = 1;

   // Distance between reference steps in meters
   localparam logic [10:0] STEP_METERS = 11'h0c8;
   localparam logic [10:0] MAX_METERS = 11'h3e8;

   // Measurement sequencer states
   typedef enum logic [1:0] {
      CDCR_IDLE = 2'b00,
      CDCR_WAIT = 2'b01,
      CDCR_CALC = 2'b10
   } cdcr_fsm_t;

   // Classic Wishbone request and answer
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [13:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
   } cdcr_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } cdcr_wb_rsp_t;

   // Measurement handed over by the diagnostic engine
   typedef struct packed {
      logic valid;
      logic [11:0] metric;
   } cdcr_meas_t;

   // Whole state of the bank
   typedef struct packed {
      logic [5:0][11:0] ref_metric;
      logic [5:0][7:0] calib;
      logic [11:0] metric;
      logic done;
      logic [10:0] length;
      cdcr_fsm_t fsm;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic irq;
      cdcr_wb_rsp_t rsp;
   } cdcr_state_t;

endpackage

// ===== rtl/cdcr_regs.sv
// Cable diagnostic calibration register bank with length estimator and Wishbone slave
`timescale 1ns/10ps
// Operation
// - The 200 m reference metric for one volt amplitude is a 12-bit read-write field in bits 11-0, reset 0x41.
// - The 400 m reference metric for one volt amplitude is a 12-bit read-write field, reset 0x58.
// - The 600 m reference metric for one volt amplitude is a 12-bit read-write field in bits 11-0, reset 0x89.
// - The 800 m reference metric for one volt amplitude is a 12-bit read-write field in bits 11-0, reset 0xB2.
// - The 1000 m reference metric for one volt amplitude is a 12-bit read-write field in bits 11-0, reset 0x107.
// - Calibration entry 0 is an 8-bit read-write field in bits 7-0, upper byte reads zero, reset 0x0.
// - Calibration entries 1 and 2 are 8-bit read-write fields with resets 0x19 and 0x2F.
// - Calibration entries 3, 4 and 5 are 8-bit read-write fields with resets 0x51, 0x64 and 0x7A.
// - The measured metric reads back as 12 bits in bits 15-4 with bits 3-0 zero, and is zero after reset.
// - Status bit 15 reads 0 while a measurement runs and 1 once it has completed.
// - Status bits 10-0 give the estimated cable length in meters, with bits 14-11 reading zero.
// - The 0 m reference metric for one volt amplitude is a 12-bit read-write field, reset 0x2E.
module cdcr_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire cdcr_pkg::cdcr_wb_req_t wb_req_i,
   output cdcr_pkg::cdcr_wb_rsp_t wb_rsp_o,
   // Measurement from the diagnostic engine
   input wire cdcr_pkg::cdcr_meas_t meas_i,
   // Interrupt
   output logic irq_o
);
   import cdcr_pkg::*;

   cdcr_state_t s_r;
   cdcr_state_t s_nxt;

   logic req;
   logic wr_now;
   logic [11:0] widx;
   logic [15:0] rdata;
   logic [2:0] step_idx;
   logic start_wr;
   logic [1:0] irq_ev;

   // Merge a 16-bit register with write data under the two low byte lanes
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] sel);
      logic [15:0] res;
      res = old;
      if (sel[0]) begin
         res[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction

   // Highest reference step that the metric has reached; a larger metric means a longer cable
   function automatic logic [2:0] reached_step(input logic [11:0] metric,
                                               input logic [5:0][11:0] refs);
      logic [2:0] k;
      k = 3'h0;
      for (int i = 1; i < 6; i++) begin
         if (metric >= refs[i]) begin
            k = 3'(i);
         end
      end
      return k;
   endfunction

   // Bus decode helpers; a write lands on the edge where the master sees ack
   assign req = wb_req_i.cyc & wb_req_i.stb;
   assign widx = wb_req_i.adr[13:2];
   assign wr_now = req & wb_req_i.we & s_r.rsp.ack;
   assign start_wr = wr_now & (widx == IDX_CTRL) & wb_req_i.sel[0] & wb_req_i.dat[CTRL_START_BIT];
   assign step_idx = reached_step(s_r.metric, s_r.ref_metric);

   // Read multiplexer; unmapped and reserved bits read as zero
   always_comb begin
      rdata = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         if (widx == REF_IDX[i]) begin
            rdata = {4'h0, s_r.ref_metric[i]};
         end
         if (widx == CAL_IDX[i]) begin
            rdata = {8'h00, s_r.calib[i]};
         end
      end
      if (widx == IDX_METRIC) begin
         rdata = {s_r.metric, 4'h0};
      end
      if (widx == IDX_STATUS) begin
         rdata = {s_r.done, 4'h0, s_r.length};
      end
      if (widx == IDX_IRQ_STAT) begin
         rdata = {14'h0000, s_r.irq_stat};
      end
      if (widx == IDX_IRQ_MASK) begin
         rdata = {14'h0000, s_r.irq_mask};
      end
   end

   // Next state of the whole bank
   always_comb begin
      s_nxt = s_r;
      irq_ev = 2'b00;
      // One-cycle ack per request, read data captured with it
      s_nxt.rsp.ack = req & ~s_r.rsp.ack;
      s_nxt.rsp.dat = (req & ~s_r.rsp.ack) ? {16'h0000, rdata} : 32'h0000_0000;

      // Measurement sequencer
      unique case (s_r.fsm)
         CDCR_IDLE: begin
            s_nxt.fsm = CDCR_IDLE;
         end
         CDCR_WAIT: begin
            if (meas_i.valid) begin
               s_nxt.metric = meas_i.metric;
               s_nxt.fsm = CDCR_CALC;
            end
         end
         CDCR_CALC: begin
            // Comparison runs a cycle after capture to keep the compare chain off the input path
            s_nxt.length = 11'(step_idx * STEP_METERS);
            s_nxt.done = 1'b1;
            s_nxt.fsm = CDCR_IDLE;
            irq_ev[IRQ_DONE_BIT] = 1'b1;
            irq_ev[IRQ_RANGE_BIT] = (step_idx == 3'h5);
         end
         default: begin
            s_nxt.fsm = CDCR_IDLE;
         end
      endcase

      // Software writes to the configuration tables
      if (wr_now) begin
         for (int i = 0; i < 6; i++) begin
            if (widx == REF_IDX[i]) begin
               s_nxt.ref_metric[i] = 12'(lane_merge({4'h0, s_r.ref_metric[i]}, wb_req_i.dat[15:0],
                                                    wb_req_i.sel[1:0]));
            end
            if (widx == CAL_IDX[i]) begin
               s_nxt.calib[i] = 8'(lane_merge({8'h00, s_r.calib[i]}, wb_req_i.dat[15:0],
                                              wb_req_i.sel[1:0]));
            end
         end
         if ((widx == IDX_IRQ_MASK) & wb_req_i.sel[0]) begin
            s_nxt.irq_mask = wb_req_i.dat[1:0];
         end
      end

      // A start restarts any running measurement and clears completion
      if (start_wr) begin
         s_nxt.done = 1'b0;
         s_nxt.fsm = CDCR_WAIT;
      end

      // Write one to clear, but an event in the same cycle wins
      if (wr_now & (widx == IDX_IRQ_STAT) & wb_req_i.sel[0]) begin
         s_nxt.irq_stat = s_r.irq_stat & ~wb_req_i.dat[1:0];
      end
      s_nxt.irq_stat = s_nxt.irq_stat | irq_ev;
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   // State register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r.ref_metric <= REF_RST;
         s_r.calib <= CAL_RST;
         s_r.metric <= 12'h000;
         s_r.done <= 1'b0;
         s_r.length <= 11'h000;
         s_r.fsm <= CDCR_IDLE;
         s_r.irq_stat <= 2'b00;
         s_r.irq_mask <= 2'b00;
         s_r.irq <= 1'b0;
         s_r.rsp <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state flops
   assign wb_rsp_o = s_r.rsp;
   assign irq_o = s_r.irq;

   // Checks
   logic rd_cal_hit;
   logic rd_metric_hit;
   logic wr_ref1_full;
   assign rd_cal_hit = req & ~wb_req_i.we & ~s_r.rsp.ack & ((widx == IDX_CAL_0) | (widx == IDX_CAL_5));
   assign rd_metric_hit = req & ~wb_req_i.we & ~s_r.rsp.ack & (widx == IDX_METRIC);
   assign wr_ref1_full = wr_now & (widx == IDX_REF_200M) & (wb_req_i.sel[1:0] == 2'b11);

   a_ack_one_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      s_r.rsp.ack |=> !s_r.rsp.ack) else $error("ack held longer than one cycle");

   a_ack_answers_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !s_r.rsp.ack) |=> s_r.rsp.ack) else $error("request not answered next cycle");

   a_ref_reset_vals: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (s_r.ref_metric[0] == 12'h02e && s_r.ref_metric[1] == 12'h041 &&
                       s_r.ref_metric[2] == 12'h058 && s_r.ref_metric[3] == 12'h089 &&
                       s_r.ref_metric[4] == 12'h0b2 && s_r.ref_metric[5] == 12'h107))
      else $error("reference metric reset value wrong");

   a_cal_reset_vals: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (s_r.calib[0] == 8'h00 && s_r.calib[1] == 8'h19 && s_r.calib[2] == 8'h2f &&
                       s_r.calib[3] == 8'h51 && s_r.calib[4] == 8'h64 && s_r.calib[5] == 8'h7a))
      else $error("calibration reset value wrong");

   a_ref_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_ref1_full |=> s_r.ref_metric[1] == $past(wb_req_i.dat[11:0]))
      else $error("reference write not stored");

   a_cal_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_cal_hit |=> (s_r.rsp.ack && s_r.rsp.dat[31:8] == 24'h000000))
      else $error("calibration upper bits not zero");

   a_metric_layout: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_metric_hit |=> (s_r.rsp.dat[3:0] == 4'h0 && s_r.rsp.dat[15:4] == $past(s_r.metric)))
      else $error("metric read layout wrong");

   a_start_clears_done: assert property (@(posedge clk_i) disable iff (rst_i)
      start_wr |=> (!s_r.done && s_r.fsm == CDCR_WAIT)) else $error("start did not clear completion");

   a_done_after_meas: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.fsm == CDCR_WAIT && meas_i.valid && !start_wr) |=> ##1 (s_r.done || $past(start_wr)))
      else $error("completion not set two cycles after measurement");

   a_length_steps: assert property (@(posedge clk_i) disable iff (rst_i)
      s_r.done |-> (s_r.length <= MAX_METERS && (s_r.length % STEP_METERS) == 11'h000))
      else $error("cable length out of step grid");

   a_done_sets_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(s_r.done) |-> s_r.irq_stat[IRQ_DONE_BIT]) else $error("completion event not latched");

   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == |(s_r.irq_stat & s_r.irq_mask)) else $error("interrupt output disagrees with status");

   // Helpers for the field checks: a full-width write where it lands, a read where it is taken
   logic wr_full;
   logic rd_take;
   logic calc_now;
   assign wr_full = wr_now & (wb_req_i.sel[1:0] == 2'b11);
   assign rd_take = req & ~wb_req_i.we & ~s_r.rsp.ack;
   assign calc_now = (s_r.fsm == CDCR_CALC);

   a_ref0_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_full && widx == IDX_REF_0M) |=> s_r.ref_metric[0] == $past(wb_req_i.dat[11:0]))
      else $error("0 m reference write not stored");

   a_ref2_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_full && widx == IDX_REF_400M) |=> s_r.ref_metric[2] == $past(wb_req_i.dat[11:0]))
      else $error("400 m reference write not stored");

   a_ref3_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_full && widx == IDX_REF_600M) |=> s_r.ref_metric[3] == $past(wb_req_i.dat[11:0]))
      else $error("600 m reference write not stored");

   a_ref4_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_full && widx == IDX_REF_800M) |=> s_r.ref_metric[4] == $past(wb_req_i.dat[11:0]))
      else $error("800 m reference write not stored");

   a_ref5_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_full && widx == IDX_REF_1000M) |=> s_r.ref_metric[5] == $past(wb_req_i.dat[11:0]))
      else $error("1000 m reference write not stored");

   a_cal0_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && wb_req_i.sel[0] && widx == IDX_CAL_0) |=> s_r.calib[0] == $past(wb_req_i.dat[7:0]))
      else $error("calibration entry 0 write not stored");

   a_cal1_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && wb_req_i.sel[0] && widx == IDX_CAL_1) |=> s_r.calib[1] == $past(wb_req_i.dat[7:0]))
      else $error("calibration entry 1 write not stored");

   a_cal2_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && wb_req_i.sel[0] && widx == IDX_CAL_2) |=> s_r.calib[2] == $past(wb_req_i.dat[7:0]))
      else $error("calibration entry 2 write not stored");

   a_cal3_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && wb_req_i.sel[0] && widx == IDX_CAL_3) |=> s_r.calib[3] == $past(wb_req_i.dat[7:0]))
      else $error("calibration entry 3 write not stored");

   a_cal4_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && wb_req_i.sel[0] && widx == IDX_CAL_4) |=> s_r.calib[4] == $past(wb_req_i.dat[7:0]))
      else $error("calibration entry 4 write not stored");

   a_cal5_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && wb_req_i.sel[0] && widx == IDX_CAL_5) |=> s_r.calib[5] == $past(wb_req_i.dat[7:0]))
      else $error("calibration entry 5 write not stored");

   a_ref0_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_take && widx == IDX_REF_0M) |=> s_r.rsp.dat[15:0] == {4'h0, $past(s_r.ref_metric[0])})
      else $error("0 m reference read wrong");

   a_ref1_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_take && widx == IDX_REF_200M) |=> s_r.rsp.dat[15:0] == {4'h0, $past(s_r.ref_metric[1])})
      else $error("200 m reference read wrong");

   a_ref2_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_take && widx == IDX_REF_400M) |=> s_r.rsp.dat[15:0] == {4'h0, $past(s_r.ref_metric[2])})
      else $error("400 m reference read wrong");

   a_ref3_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_take && widx == IDX_REF_600M) |=> s_r.rsp.dat[15:0] == {4'h0, $past(s_r.ref_metric[3])})
      else $error("600 m reference read wrong");

   a_ref4_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_take && widx == IDX_REF_800M) |=> s_r.rsp.dat[15:0] == {4'h0, $past(s_r.ref_metric[4])})
      else $error("800 m reference read wrong");

   a_ref5_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_take && widx == IDX_REF_1000M) |=> s_r.rsp.dat[15:0] == {4'h0, $past(s_r.ref_metric[5])})
      else $error("1000 m reference read wrong");

   a_status_read_layout: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_take && widx == IDX_STATUS) |=> s_r.rsp.dat[15:0] == {$past(s_r.done), 4'h0, $past(s_r.length)})
      else $error("status read layout wrong");

   a_metric_read_only: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && widx == IDX_METRIC && !(s_r.fsm == CDCR_WAIT && meas_i.valid)) |=> $stable(s_r.metric))
      else $error("write reached the measured metric");

   a_status_read_only: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && widx == IDX_STATUS && !calc_now) |=> ($stable(s_r.length) && $stable(s_r.done)))
      else $error("write reached the status word");

   a_metric_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.fsm == CDCR_WAIT && meas_i.valid) |=> s_r.metric == $past(meas_i.metric))
      else $error("measured metric not captured");

   a_metric_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(s_r.fsm == CDCR_WAIT && meas_i.valid) |=> $stable(s_r.metric))
      else $error("measured metric changed without a capture");

   a_busy_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      s_r.fsm != CDCR_IDLE |-> !s_r.done)
      else $error("completion shown while measuring");

   a_done_means_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      s_r.done |-> s_r.fsm == CDCR_IDLE)
      else $error("completion shown with sequencer busy");

   a_length_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      s_r.done |=> $stable(s_r.length))
      else $error("cable length changed after completion");

   // A short cable reaches no step at all, whatever order software left the references in
   a_length_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (calc_now && s_r.metric < s_r.ref_metric[1] && s_r.metric < s_r.ref_metric[2] &&
       s_r.metric < s_r.ref_metric[3] && s_r.metric < s_r.ref_metric[4] &&
       s_r.metric < s_r.ref_metric[5]) |=> s_r.length == 11'h000)
      else $error("short cable not reported as zero length");

   a_length_mid_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (calc_now && s_r.metric >= s_r.ref_metric[3] && s_r.metric < s_r.ref_metric[4] &&
       s_r.metric < s_r.ref_metric[5]) |=> s_r.length == 11'(3 * STEP_METERS))
      else $error("600 m step not reported");

   a_length_top_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (calc_now && s_r.metric >= s_r.ref_metric[5]) |=> s_r.length == MAX_METERS)
      else $error("longest step not reported");

   a_range_event: assert property (@(posedge clk_i) disable iff (rst_i)
      (calc_now && s_r.metric >= s_r.ref_metric[5]) |=> s_r.irq_stat[IRQ_RANGE_BIT])
      else $error("beyond-last-step event not latched");

   a_done_bit_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_now && widx == IDX_IRQ_STAT && wb_req_i.sel[0] && wb_req_i.dat[IRQ_DONE_BIT] && !calc_now)
      |=> !s_r.irq_stat[IRQ_DONE_BIT])
      else $error("write one did not clear the done event");

   a_rdata_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_r.rsp.ack |-> s_r.rsp.dat == 32'h0000_0000)
      else $error("read data not zero outside ack");

   a_rdata_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      s_r.rsp.ack |-> s_r.rsp.dat[31:16] == 16'h0000)
      else $error("upper half of read data not zero");

endmodule

// ===== tb/cdcr_regs_bench.sv
// Self-checking bench for the cable diagnostic calibration register bank
`timescale 1ns/10ps
module cdcr_regs_bench;
   import cdcr_pkg::*;

   // Compare one value, count it, report a mismatch at once
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin error_cnt++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

   logic clk_i;
   logic rst_i;
   cdcr_wb_req_t req;
   cdcr_wb_rsp_t rsp;
   cdcr_meas_t meas;
   logic irq_o;
   int error_cnt = 0;
   int comparisons = 0;
   logic [15:0] rd;
   // Byte lanes used by the next bus call
   logic [3:0] lanes = 4'h3;
   // Expected reset values, 0 m step first
   logic [11:0] ref_exp [6] = '{12'h02e, 12'h041, 12'h058, 12'h089, 12'h0b2, 12'h107};
   logic [7:0] cal_exp [6] = '{8'h00, 8'h19, 8'h2f, 8'h51, 8'h64, 8'h7a};
   // Measurement cases: metric and expected length, with a boundary hit on the 200 m step
   logic [11:0] m_tab [4] = '{12'h020, 12'h041, 12'h0a0, 12'h200};
   logic [10:0] l_tab [4] = '{11'h000, 11'h0c8, 11'h258, 11'h3e8};

   cdcr_regs i_dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_req_i(req),
      .wb_rsp_o(rsp),
      .meas_i(meas),
      .irq_o(irq_o)
   );

   // Clock at 250 MHz
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Verdict and end of run, shared by the main sequence and the watchdog
   task automatic end_sim();
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One classic Wishbone cycle; holds the request until ack is seen at an edge
   task automatic bus(input logic [11:0] idx, input logic we, input logic [15:0] wd, output logic [15:0] rdat);
      int n;
      n = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, dat: {16'h0000, wd}, sel: lanes};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         $display("[ERR] ack expected 1 seen none");
      end
      rdat = rsp.dat[15:0];
      req <= '0;
   endtask

   // Start a measurement, feed one metric, check flag, length and metric readback
   task automatic measure(input logic [11:0] m, input logic [10:0] len);
      bus(IDX_CTRL, 1'b1, 16'h0001, rd);
      bus(IDX_STATUS, 1'b0, 16'h0000, rd);
      `CHK("busy flag", 1'b0, rd[15])
      @(posedge clk_i);
      meas <= '{valid: 1'b1, metric: m};
      @(posedge clk_i);
      meas <= '0;
      repeat (2) @(posedge clk_i);
      bus(IDX_STATUS, 1'b0, 16'h0000, rd);
      `CHK("status", {1'b1, 4'h0, len}, rd)
      bus(IDX_METRIC, 1'b0, 16'h0000, rd);
      `CHK("metric", {m, 4'h0}, rd)
   endtask

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      end_sim();
   end

   // Main sequence
   initial begin
      rst_i = 1'b1;
      req = '0;
      meas = '0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, then all-ones writes show only the field bits stick
      for (int i = 0; i < 6; i++) begin
         bus(REF_IDX[i], 1'b0, 16'h0000, rd);
         `CHK("ref reset", {4'h0, ref_exp[i]}, rd)
         bus(CAL_IDX[i], 1'b0, 16'h0000, rd);
         `CHK("cal reset", {8'h00, cal_exp[i]}, rd)
         bus(REF_IDX[i], 1'b1, 16'hffff, rd);
         bus(REF_IDX[i], 1'b0, 16'h0000, rd);
         `CHK("ref rw", 16'h0fff, rd)
         bus(CAL_IDX[i], 1'b1, 16'hffff, rd);
         bus(CAL_IDX[i], 1'b0, 16'h0000, rd);
         `CHK("cal rw", 16'h00ff, rd)
         bus(REF_IDX[i], 1'b1, {4'h0, ref_exp[i]}, rd);
      end
      bus(IDX_METRIC, 1'b0, 16'h0000, rd);
      `CHK("metric reset", 16'h0000, rd)
      bus(IDX_STATUS, 1'b0, 16'h0000, rd);
      `CHK("status reset", 16'h0000, rd)
      // Read-only and unmapped places ignore writes
      bus(IDX_METRIC, 1'b1, 16'hffff, rd);
      bus(IDX_STATUS, 1'b1, 16'hffff, rd);
      bus(IDX_METRIC, 1'b0, 16'h0000, rd);
      `CHK("metric ro", 16'h0000, rd)
      bus(IDX_STATUS, 1'b0, 16'h0000, rd);
      `CHK("status ro", 16'h0000, rd)
      bus(12'h123, 1'b1, 16'hffff, rd);
      bus(12'h123, 1'b0, 16'h0000, rd);
      `CHK("unmapped", 16'h0000, rd)
      // Length table walk with completion interrupt unmasked
      bus(IDX_IRQ_MASK, 1'b1, 16'h0001, rd);
      for (int k = 0; k < 4; k++) begin
         measure(m_tab[k], l_tab[k]);
         `CHK("irq on done", 1'b1, irq_o)
      end
      // A pulse after completion is ignored
      @(posedge clk_i);
      meas <= '{valid: 1'b1, metric: 12'h7ff};
      @(posedge clk_i);
      meas <= '0;
      bus(IDX_METRIC, 1'b0, 16'h0000, rd);
      `CHK("late pulse", 16'h2000, rd)
      // Sticky bits, write-one-to-clear, masking
      bus(IDX_IRQ_STAT, 1'b0, 16'h0000, rd);
      `CHK("irq stat", 16'h0003, rd)
      bus(IDX_IRQ_STAT, 1'b1, 16'h0001, rd);
      repeat (2) @(posedge clk_i);
      `CHK("irq masked", 1'b0, irq_o)
      bus(IDX_IRQ_MASK, 1'b1, 16'h0002, rd);
      repeat (2) @(posedge clk_i);
      `CHK("irq range", 1'b1, irq_o)
      bus(IDX_IRQ_STAT, 1'b1, 16'h0002, rd);
      repeat (2) @(posedge clk_i);
      `CHK("irq cleared", 1'b0, irq_o)
      bus(IDX_IRQ_STAT, 1'b0, 16'h0000, rd);
      `CHK("irq stat clr", 16'h0000, rd)
      // Each byte lane reaches only its own half; the reserved nibble is dropped
      lanes = 4'h1;
      bus(IDX_REF_200M, 1'b1, 16'hfabc, rd);
      bus(IDX_REF_200M, 1'b0, 16'h0000, rd);
      `CHK("low lane", 16'h00bc, rd)
      lanes = 4'h2;
      bus(IDX_REF_200M, 1'b1, 16'h5312, rd);
      bus(IDX_REF_200M, 1'b0, 16'h0000, rd);
      `CHK("high lane", 16'h03bc, rd)
      lanes = 4'h3;
      // Reset in mid-run brings back reset values over written and measured state
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(IDX_REF_200M, 1'b0, 16'h0000, rd);
      `CHK("ref after reset", {4'h0, ref_exp[1]}, rd)
      bus(IDX_METRIC, 1'b0, 16'h0000, rd);
      `CHK("metric after reset", 16'h0000, rd)
      bus(IDX_STATUS, 1'b0, 16'h0000, rd);
      `CHK("status after reset", 16'h0000, rd)
      end_sim();
   end
endmodule
